//--- logic/bst_trig_src.sv
// burst gating package and shared trigger source
`timescale 1ns/1ns
package bst_pkg;
	localparam int PHASE_W       = 32;
	localparam int MARK_W        = 21;
	localparam int CNT_W         = 32;
	localparam int SAMPLE_W      = 16;
	localparam int PCT_W         = 8;
	localparam int PERIOD_W      = 32;
	localparam int CLK_FREQ_HZ   = 125_000_000;
	localparam int LAMP_TIME_MS  = 100;
	localparam int LAMP_CYCLES   = LAMP_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam logic [MARK_W-1:0] MARK_HALF_MAX = 21'h1E_847F;
	localparam logic signed [SAMPLE_W-1:0] FULL_SCALE = 16'sh7FFF;
	localparam int PCT_FULL      = 100;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_DELAY = 3'b001,
		ST_MARK  = 3'b010,
		ST_SPACE = 3'b011,
		ST_DRAIN = 3'b100
	} bst_state_t;

	typedef enum logic [2:0] {
		AUX_SYNC    = 3'b000,
		AUX_GATE    = 3'b001,
		AUX_MODULATOR_PHASE_PULSE = 3'b010,
		AUX_MODWAVE = 3'b011,
		AUX_SUBWAVE = 3'b100,
		AUX_OFF     = 3'b101
	} bst_aux_t;

	typedef enum logic [1:0] {
		ROUTE_LOGIC   = 2'b00,
		ROUTE_MODWAVE = 2'b01,
		ROUTE_SUBWAVE = 2'b10
	} bst_route_t;

	typedef enum logic [2:0] {
		WAVE_SINE = 3'b000, WAVE_SQUARE = 3'b001, WAVE_TRI  = 3'b010,
		WAVE_RAMP = 3'b011, WAVE_PULSE  = 3'b100, WAVE_NOISE = 3'b101,
		WAVE_DC   = 3'b110, WAVE_ARB    = 3'b111
	} bst_wave_t;

	typedef enum logic [1:0] {
		POL_RISE = 2'b00,
		POL_FALL = 2'b01,
		POL_OFF  = 2'b10
	} bst_pol_t;

	typedef enum logic {
		MODE_TRIGGERED = 1'b0,
		MODE_FREE      = 1'b1
	} bst_mode_t;

	typedef struct packed {
		logic                  use_ext;
		bst_pol_t              polarity;
		logic [SAMPLE_W-1:0]   threshold;
		logic [PERIOD_W-1:0]   int_period;
	} bst_trig_cfg_t;

	typedef struct packed {
		bst_mode_t             gating_mode_select;
		logic [MARK_W-1:0]     mark_half;
		logic                  mark_endless;
		logic [MARK_W-1:0]     space_half;
		logic [CNT_W-1:0]      start_delay_time;
		logic                  idle_level_option;
		logic signed [PCT_W-1:0] idle_level_pct;
		logic                  halt_granularity;
		logic [PHASE_W-1:0]    start_phase;
	} bst_burst_cfg_t;
endpackage : bst_pkg

module bst_trig_src (
	// clock and reset
	input  wire logic                        clk_sys_i,
	input  wire logic                        srst_i,
	// source configuration
	input  wire bst_pkg::bst_trig_cfg_t      cfg_i,
	// trigger origins
	input  wire logic                        ext_trig_pin_i,
	input  wire logic                        manual_key_i,
	input  wire logic                        remote_trig_i,
	// results
	output logic                             trig_o,
	output logic [bst_pkg::SAMPLE_W-1:0]     threshold_o
);
	logic                          ext_meta_r, ext_sync_r, ext_prev_r;
	logic                          key_meta_r, key_sync_r, key_prev_r;
	logic [bst_pkg::PERIOD_W-1:0]  tick_cnt_r;
	logic                          tick_c, ext_edge_c;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			{ext_meta_r, ext_sync_r, ext_prev_r} <= 3'h0;
			{key_meta_r, key_sync_r, key_prev_r} <= 3'h0;
		end else begin
			ext_meta_r <= ext_trig_pin_i;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
			key_meta_r <= manual_key_i;
			key_sync_r <= key_meta_r;
			key_prev_r <= key_sync_r;
		end
	end

	assign tick_c = (tick_cnt_r + 32'h0000_0001) >= cfg_i.int_period;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || cfg_i.use_ext || tick_c)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
	end

	always_comb begin
		unique case (cfg_i.polarity)
			bst_pkg::POL_RISE: ext_edge_c = ext_sync_r & ~ext_prev_r;
			bst_pkg::POL_FALL: ext_edge_c = ~ext_sync_r & ext_prev_r;
			default:           ext_edge_c = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			trig_o      <= 1'b0;
			threshold_o <= '0;
		end else begin
			trig_o <= (cfg_i.use_ext ? ext_edge_c : tick_c)
				| (key_sync_r & ~key_prev_r) | remote_trig_i;
			threshold_o <= cfg_i.threshold;
		end
	end
endmodule : bst_trig_src

//--- logic/bst_phase_acc.sv
// phase accumulator with half and full cycle boundary events
`timescale 1ns/1ns
module bst_phase_acc #(
	parameter int PHASE_W = bst_pkg::PHASE_W
) (
	// clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               srst_i,
	// control
	input  wire logic [PHASE_W-1:0] freq_word_i,
	input  wire logic [PHASE_W-1:0] start_phase_i,
	input  wire logic               load_i,
	input  wire logic               run_i,
	// results
	output logic [PHASE_W-1:0]      phase_o,
	output logic                    half_evt_o,
	output logic                    full_evt_o,
	output logic                    ref_sync_o
);
	logic [PHASE_W-1:0] nxt_c, rel_now_c, rel_nxt_c;

	assign nxt_c     = phase_o + freq_word_i;
	assign rel_now_c = phase_o - start_phase_i;
	assign rel_nxt_c = nxt_c - start_phase_i;
	// boundary at start phase or opposite
	assign half_evt_o = run_i &
		(rel_now_c[PHASE_W-1] != rel_nxt_c[PHASE_W-1]);
	assign full_evt_o = run_i & rel_now_c[PHASE_W-1] &
		~rel_nxt_c[PHASE_W-1];

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			phase_o <= '0;
		else if (load_i)
			phase_o <= start_phase_i;
		else if (run_i)
			phase_o <= nxt_c;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			ref_sync_o <= 1'b0;
		else
			ref_sync_o <= ~phase_o[PHASE_W-1];
	end
endmodule : bst_phase_acc

//--- logic/bst_gate_ctrl.sv
// burst gating controller top
`timescale 1ns/1ns
module bst_gate_ctrl #(
	parameter int LAMP_CYCLES = bst_pkg::LAMP_CYCLES
) (
	// clock and reset
	input  wire logic                               clk_sys_i,
	input  wire logic                               srst_i,
	// configuration
	input  wire logic                               burst_en_i,
	input  wire bst_pkg::bst_burst_cfg_t            cfg_i,
	input  wire bst_pkg::bst_trig_cfg_t             trig_cfg_i,
	input  wire bst_pkg::bst_wave_t                 wave_kind_i,
	input  wire bst_pkg::bst_aux_t                  aux_output_select_i,
	input  wire logic                               int_mod_i,
	input  wire logic [bst_pkg::PHASE_W-1:0]        freq_word_i,
	input  wire logic                               ext_conflict_i,
	// trigger and stop requests
	input  wire logic                               ext_trig_pin_i,
	input  wire logic                               manual_key_i,
	input  wire logic                               remote_trig_i,
	input  wire logic                               stop_req_i,
	// waveform path
	input  wire logic signed [bst_pkg::SAMPLE_W-1:0] sample_i,
	input  wire logic                               modulator_phase_pulse_i,
	// outputs
	output logic signed [bst_pkg::SAMPLE_W-1:0]     wave_out_o,
	output logic [bst_pkg::PHASE_W-1:0]             phase_o,
	output logic                                    osc_active_o,
	output logic                                    aux_sync_o,
	output bst_pkg::bst_route_t                     aux_route_o,
	output logic                                    conflict_o,
	output logic                                    trig_lamp_o,
	output logic                                    trig_shared_o,
	output logic [bst_pkg::SAMPLE_W-1:0]            trig_threshold_o
);
	bst_pkg::bst_state_t               state_r;
	bst_pkg::bst_mode_t                mode_prev_r;
	logic [bst_pkg::CNT_W-1:0]         cnt_r;
	logic [bst_pkg::CNT_W-1:0]         cnt_inc_c;
	logic [bst_pkg::CNT_W-1:0]         lamp_cnt_r;
	logic signed [bst_pkg::SAMPLE_W-1:0] held_r;
	logic signed [bst_pkg::SAMPLE_W-1:0] level_c;
	logic signed [bst_pkg::SAMPLE_W+bst_pkg::PCT_W-1:0] prod_c;
	logic                              trig_c;
	logic                              half_evt_c, full_evt_c, ref_sync_c;
	logic                              refused_c, conflict_c, mode_chg_c;
	logic                              ok_c, free_c, osc_c;
	logic                              mark_done_c, space_done_c, stop_evt_c;
	logic                              load_c, run_c;

	bst_trig_src u_trig (
		.clk_sys_i      (clk_sys_i),
		.srst_i         (srst_i),
		.cfg_i          (trig_cfg_i),
		.ext_trig_pin_i (ext_trig_pin_i),
		.manual_key_i   (manual_key_i),
		.remote_trig_i  (remote_trig_i),
		.trig_o         (trig_c),
		.threshold_o    (trig_threshold_o)
	);

	bst_phase_acc u_phase (
		.clk_sys_i     (clk_sys_i),
		.srst_i        (srst_i),
		.freq_word_i   (freq_word_i),
		.start_phase_i (cfg_i.start_phase),
		.load_i        (load_c),
		.run_i         (run_c),
		.phase_o       (phase_o),
		.half_evt_o    (half_evt_c),
		.full_evt_o    (full_evt_c),
		.ref_sync_o    (ref_sync_c)
	);

	assign trig_shared_o = trig_c;
	assign free_c     = cfg_i.gating_mode_select == bst_pkg::MODE_FREE;
	assign mode_chg_c = cfg_i.gating_mode_select != mode_prev_r;
	assign refused_c  = (wave_kind_i == bst_pkg::WAVE_NOISE) ||
		(wave_kind_i == bst_pkg::WAVE_DC);
	assign conflict_c = burst_en_i & (refused_c | ext_conflict_i |
		(!cfg_i.mark_endless && cfg_i.mark_half == '0) |
		(cfg_i.mark_half > bst_pkg::MARK_HALF_MAX) |
		(free_c && (cfg_i.mark_endless || cfg_i.space_half == '0)));
	assign ok_c    = burst_en_i & ~conflict_c & ~mode_chg_c;
	assign cnt_inc_c = cnt_r + 32'h0000_0001;
	assign mark_done_c = (state_r == bst_pkg::ST_MARK) & half_evt_c &
		~cfg_i.mark_endless & (cnt_inc_c == 32'(cfg_i.mark_half));
	assign space_done_c = (state_r == bst_pkg::ST_SPACE) & half_evt_c &
		(cnt_inc_c == 32'(cfg_i.space_half));
	assign stop_evt_c = cfg_i.halt_granularity ? half_evt_c : full_evt_c;
	assign osc_c = (state_r == bst_pkg::ST_MARK) ||
		(state_r == bst_pkg::ST_DRAIN);
	assign run_c = osc_c || (state_r == bst_pkg::ST_SPACE);
	// each burst begins at start phase
	assign load_c = (state_r == bst_pkg::ST_IDLE) ||
		(state_r == bst_pkg::ST_DELAY) || space_done_c;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			mode_prev_r <= bst_pkg::MODE_TRIGGERED;
		else
			mode_prev_r <= cfg_i.gating_mode_select;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_r <= bst_pkg::ST_IDLE;
			cnt_r   <= '0;
		end else if (burst_en_i && (mode_chg_c || conflict_c)) begin
			state_r <= bst_pkg::ST_IDLE;
			cnt_r   <= '0;
		end else if (!burst_en_i) begin
			// leaving burst mode drains to boundary
			if (state_r == bst_pkg::ST_MARK)
				state_r <= bst_pkg::ST_DRAIN;
			else if (state_r != bst_pkg::ST_DRAIN || stop_evt_c)
				state_r <= bst_pkg::ST_IDLE;
			cnt_r <= '0;
		end else begin
			unique case (state_r)
				bst_pkg::ST_IDLE: begin
					cnt_r <= '0;
					if (free_c)
						state_r <= bst_pkg::ST_MARK;
					else if (trig_c && cfg_i.start_delay_time == '0)
						state_r <= bst_pkg::ST_MARK;
					else if (trig_c) begin
						state_r <= bst_pkg::ST_DELAY;
						cnt_r   <= 32'h0000_0001;
					end
				end
				bst_pkg::ST_DELAY: begin
					if (cnt_r >= cfg_i.start_delay_time) begin
						state_r <= bst_pkg::ST_MARK;
						cnt_r   <= '0;
					end else
						cnt_r <= cnt_inc_c;
				end
				bst_pkg::ST_MARK: begin
					if (cfg_i.mark_endless && stop_req_i)
						state_r <= bst_pkg::ST_DRAIN;
					else if (mark_done_c) begin
						state_r <= free_c ? bst_pkg::ST_SPACE
							: bst_pkg::ST_IDLE;
						cnt_r   <= '0;
					end else if (half_evt_c && !cfg_i.mark_endless)
						cnt_r <= cnt_inc_c;
				end
				bst_pkg::ST_SPACE: begin
					if (space_done_c) begin
						state_r <= bst_pkg::ST_MARK;
						cnt_r   <= '0;
					end else if (half_evt_c)
						cnt_r <= cnt_inc_c;
				end
				bst_pkg::ST_DRAIN: begin
					if (stop_evt_c)
						state_r <= bst_pkg::ST_IDLE;
				end
				default: begin
					state_r <= bst_pkg::ST_IDLE;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	// idle level as share of full scale
	always_comb begin
		prod_c  = cfg_i.idle_level_pct * bst_pkg::FULL_SCALE;
		level_c = bst_pkg::SAMPLE_W'(prod_c / bst_pkg::PCT_FULL);
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			held_r       <= '0;
			wave_out_o   <= '0;
			osc_active_o <= 1'b0;
			conflict_o   <= 1'b0;
		end else begin
			if (state_r == bst_pkg::ST_IDLE || state_r == bst_pkg::ST_DELAY)
				held_r <= sample_i;
			if (osc_c)
				wave_out_o <= sample_i;
			else if (cfg_i.idle_level_option)
				wave_out_o <= level_c;
			else if (state_r == bst_pkg::ST_SPACE)
				wave_out_o <= held_r;
			else
				wave_out_o <= sample_i;
			osc_active_o <= osc_c;
			conflict_o   <= conflict_c;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			lamp_cnt_r <= '0;
		else if (trig_c && burst_en_i && !free_c)
			lamp_cnt_r <= 32'(LAMP_CYCLES);
		else if (lamp_cnt_r != '0)
			lamp_cnt_r <= lamp_cnt_r - 32'h0000_0001;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			trig_lamp_o <= 1'b0;
		else
			trig_lamp_o <= (trig_c && burst_en_i && !free_c) ||
				(lamp_cnt_r > 32'h0000_0001);
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			aux_sync_o  <= 1'b0;
			aux_route_o <= bst_pkg::ROUTE_LOGIC;
		end else begin
			aux_route_o <= bst_pkg::ROUTE_LOGIC;
			case (aux_output_select_i)
				bst_pkg::AUX_SYNC: aux_sync_o <= ref_sync_c;
				bst_pkg::AUX_GATE: aux_sync_o <= ~osc_c;
				bst_pkg::AUX_MODULATOR_PHASE_PULSE:
					aux_sync_o <= int_mod_i & modulator_phase_pulse_i;
				bst_pkg::AUX_MODWAVE, bst_pkg::AUX_SUBWAVE: begin
					aux_sync_o  <= 1'b0;
					aux_route_o <= int_mod_i ? bst_pkg::ROUTE_MODWAVE
						: bst_pkg::ROUTE_SUBWAVE;
				end
				default: aux_sync_o <= 1'b0;
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence s_enter_mark;
		(state_r != bst_pkg::ST_MARK) ##1 (state_r == bst_pkg::ST_MARK);
	endsequence
	sequence s_idle_ok;
		(state_r == bst_pkg::ST_IDLE) && ok_c && !free_c && trig_c;
	endsequence

	AST_CONFLICT: assert property (
		burst_en_i && refused_c |=> conflict_o)
		else $error("conflict not flagged");
	AST_REFUSE: assert property (
		burst_en_i && refused_c |=> state_r == bst_pkg::ST_IDLE ##1
			!osc_active_o)
		else $error("refused waveform still bursting");
	AST_FREE_START: assert property (
		state_r == bst_pkg::ST_IDLE && ok_c && free_c
			|=> state_r == bst_pkg::ST_MARK ##1 osc_active_o)
		else $error("free-running did not start");
	AST_ZERO_DELAY: assert property (
		s_idle_ok ##0 (cfg_i.start_delay_time == '0)
			|=> state_r == bst_pkg::ST_MARK)
		else $error("zero delay not minimal");
	AST_DELAY_ENTRY: assert property (
		s_idle_ok ##0 (cfg_i.start_delay_time != '0)
			|=> state_r == bst_pkg::ST_DELAY && cnt_r == 32'h0000_0001)
		else $error("delay not started");
	AST_MARK_END: assert property (
		mark_done_c && ok_c && !free_c |=> state_r == bst_pkg::ST_IDLE)
		else $error("mark count not honoured");
	AST_TRIG_IGNORE: assert property (
		state_r == bst_pkg::ST_MARK && trig_c
			|=> state_r != bst_pkg::ST_DELAY)
		else $error("trigger accepted mid burst");
	AST_LOAD: assert property (
		s_enter_mark ##0 $stable(cfg_i.start_phase)
			|-> phase_o == cfg_i.start_phase)
		else $error("burst not at start phase");
	AST_ENDLESS: assert property (
		state_r == bst_pkg::ST_MARK && cfg_i.mark_endless && stop_req_i
			&& ok_c |=> state_r == bst_pkg::ST_DRAIN)
		else $error("endless stop not draining");
	AST_GATE_SYNC: assert property (
		aux_output_select_i == bst_pkg::AUX_GATE
			|=> aux_sync_o == !osc_active_o)
		else $error("gating sync wrong level");
	AST_AUX_OFF: assert property (
		aux_output_select_i == bst_pkg::AUX_OFF [*2] |-> ##1 !aux_sync_o)
		else $error("aux off not low");
	AST_LAMP: assert property (
		trig_c && burst_en_i && !free_c |=> trig_lamp_o [*2])
		else $error("lamp not lit");
endmodule : bst_gate_ctrl

//--- tb/bst_ext_src.sv
// trigger pin driver and waveform sample source for the gating bench
`timescale 1ns/1ns
module bst_ext_src (
	// clock and phase
	input  wire logic                           clk_sys_i,
	input  wire logic [bst_pkg::PHASE_W-1:0]    phase_i,
	// outputs
	output logic                                pin_o,
	output logic signed [bst_pkg::SAMPLE_W-1:0] sample_o
);
	// sample follows the accumulator top bits
	assign sample_o = phase_i[bst_pkg::PHASE_W-1 -: bst_pkg::SAMPLE_W];
	initial pin_o = 1'b0;
	task automatic pulse(input int width);
		@(posedge clk_sys_i);
		#1 pin_o = 1'b1;
		repeat (width) @(posedge clk_sys_i);
		#1 pin_o = 1'b0;
	endtask : pulse
endmodule : bst_ext_src

//--- tb/bst_gate_ctrl_test.sv
// self-checking bench for the burst gating controller
`timescale 1ns/1ns
module bst_gate_ctrl_test;
	localparam logic [31:0] START_PH = 32'h1555_5555;
	logic                    clk_sys_i = 1'b0;
	logic                    srst_i = 1'b1;
	logic                    burst_en, int_mod, ext_conf, key, remote;
	logic                    stop, mps, pin, osc, aux_sync, conflict;
	logic                    lamp, shared;
	logic                    shared_seen = 1'b0;
	bst_pkg::bst_burst_cfg_t cfg;
	bst_pkg::bst_trig_cfg_t  tcfg;
	bst_pkg::bst_wave_t      wave;
	bst_pkg::bst_aux_t       aux;
	bst_pkg::bst_route_t     route;
	logic [31:0]             fw, phase;
	logic signed [15:0]      sample, wave_out;
	logic [15:0]             thr;
	int                      fail_count = 0;
	int                      total_checks = 0;
	int                      rises = 0;
	int                      n, m;

	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (shared === 1'b1) shared_seen <= 1'b1;
		if (aux_sync === 1'b1 && $past(aux_sync) === 1'b0) rises <= rises + 1;
	end

	bst_gate_ctrl #(.LAMP_CYCLES(8)) u_bst_gate_ctrl (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .burst_en_i(burst_en),
		.cfg_i(cfg), .trig_cfg_i(tcfg), .wave_kind_i(wave),
		.aux_output_select_i(aux), .int_mod_i(int_mod), .freq_word_i(fw),
		.ext_conflict_i(ext_conf), .ext_trig_pin_i(pin),
		.manual_key_i(key), .remote_trig_i(remote), .stop_req_i(stop),
		.sample_i(sample), .modulator_phase_pulse_i(mps),
		.wave_out_o(wave_out), .phase_o(phase), .osc_active_o(osc),
		.aux_sync_o(aux_sync), .aux_route_o(route), .conflict_o(conflict),
		.trig_lamp_o(lamp), .trig_shared_o(shared),
		.trig_threshold_o(thr)
	);
	bst_ext_src u_bst_ext_src (
		.clk_sys_i(clk_sys_i), .phase_i(phase), .pin_o(pin),
		.sample_o(sample)
	);

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic near(input string what, input int exp, input int got);
		chk(what, 1, got >= exp - 1 && got <= exp + 1);
	endtask : near
	task automatic fire;
		remote = 1'b1;
		cyc(1);
		remote = 1'b0;
	endtask : fire
	task automatic wait_osc(input int lim, output int k);
		k = 0;
		while (osc !== 1'b1 && k < lim) begin
			cyc(1);
			k++;
		end
	endtask : wait_osc
	task automatic run_len(output int k);
		k = 0;
		while (osc === 1'b1 && k < 5000) begin
			cyc(1);
			k++;
		end
	endtask : run_len
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial begin
		#400_000;
		fail_count++;
		test_done();
	end

	initial begin
		{burst_en, int_mod, ext_conf, key, remote, stop, mps} = 7'h01 << 6;
		fw = 32'h1000_0000;
		wave = bst_pkg::WAVE_SINE;
		aux = bst_pkg::AUX_GATE;
		tcfg = '{1'b1, bst_pkg::POL_OFF, 16'h0123, 32'h0000_0064};
		cfg = '{bst_pkg::MODE_TRIGGERED, 21'h00_0003, 1'b0, 21'h00_0004,
			32'h0000_0000, 1'b0, 8'sh00, 1'b0, START_PH};
		repeat (3) @(posedge clk_sys_i);
		#1 srst_i = 1'b0;
		cyc(4);
		chk("idle osc", 0, osc);
		chk("parked phase", START_PH, phase);
		chk("threshold", 16'h0123, thr);
		chk("idle wave", 16'h1555, wave_out);
		chk("gate idle", 1, aux_sync);
		fire();
		wait_osc(10, n);
		chk("zero delay", 2, n);
		chk("lamp", 1, lamp);
		fire();
		chk("gate active", 0, aux_sync);
		run_len(n);
		near("mark len", 24, n + 1);
		cyc(20);
		chk("retrigger", 0, osc);
		chk("lamp off", 0, lamp);
		chk("end phase", START_PH, phase);
		chk("stop value", 16'h1555, wave_out);
		cfg.start_delay_time = 32'h0000_0005;
		fire();
		wait_osc(30, n);
		chk("delay", 7, n);
		run_len(n);
		key = 1'b1;
		wait_osc(30, n);
		near("key delay", 10, n);
		run_len(n);
		key = 1'b0;
		cfg.start_delay_time = 32'h0000_0000;
		for (int p = 0; p < 3; p++) begin
			tcfg.polarity = bst_pkg::bst_pol_t'(p);
			cyc(4);
			u_bst_ext_src.pulse(3);
			wait_osc(20, n);
			chk("ext burst", p != 2, osc);
			run_len(n);
		end
		chk("shared trig", 1, shared_seen);
		tcfg.use_ext = 1'b0;
		wait_osc(300, n);
		chk("int osc burst", 1, osc);
		tcfg.use_ext = 1'b1;
		tcfg.polarity = bst_pkg::POL_OFF;
		run_len(n);
		cfg.idle_level_option = 1'b1;
		cfg.idle_level_pct = 8'sh32;
		cyc(3);
		chk("idle level", 16'h3FFF, wave_out);
		cfg.idle_level_option = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (i < 2) wave = bst_pkg::bst_wave_t'(5 + i);
			else cfg.mark_half = 21'h00_0000;
			cyc(3);
			chk("conflict", 1, conflict);
			fire();
			cyc(20);
			chk("refused", 0, osc);
		end
		wave = bst_pkg::WAVE_SINE;
		cfg.mark_half = 21'h00_0004;
		cyc(3);
		chk("no conflict", 0, conflict);
		cfg.mark_endless = 1'b1;
		for (int g = 0; g < 2; g++) begin
			cfg.halt_granularity = g[0];
			fire();
			wait_osc(10, n);
			cyc(60);
			chk("endless", 1, osc);
			stop = 1'b1;
			run_len(n);
			stop = 1'b0;
			chk("drain", 1, n <= (g ? 11 : 19));
			cyc(3);
			chk("drain phase", START_PH, phase);
		end
		cfg.mark_endless = 1'b0;
		aux = bst_pkg::AUX_OFF;
		cyc(3);
		chk("aux off", 0, aux_sync);
		aux = bst_pkg::AUX_SUBWAVE;
		cyc(3);
		chk("sub route", bst_pkg::ROUTE_SUBWAVE, route);
		int_mod = 1'b1;
		cyc(3);
		chk("mod route", bst_pkg::ROUTE_MODWAVE, route);
		int_mod = 1'b0;
		aux = bst_pkg::AUX_MODULATOR_PHASE_PULSE;
		cyc(3);
		chk("modulator_phase_pulse off", 0, aux_sync);
		aux = bst_pkg::AUX_SYNC;
		cyc(3);
		chk("sync route", bst_pkg::ROUTE_LOGIC, route);
		rises = 0;
		fire();
		wait_osc(10, n);
		run_len(n);
		chk("ref sync", 1, rises > 0);
		aux = bst_pkg::AUX_GATE;
		cfg.mark_half = 21'h00_0003;
		cfg.gating_mode_select = bst_pkg::MODE_FREE;
		wait_osc(10, n);
		chk("free start", 1, osc);
		run_len(n);
		m = 0;
		while (osc === 1'b0 && m < 500) begin
			cyc(1);
			m++;
		end
		near("space len", 32, m);
		run_len(n);
		near("free mark", 24, n);
		ext_conf = 1'b1;
		cyc(3);
		chk("free conflict", 1, conflict);
		chk("held", 0, osc);
		ext_conf = 1'b0;
		wait_osc(100, n);
		chk("resume", 1, osc);
		cfg.gating_mode_select = bst_pkg::MODE_TRIGGERED;
		cyc(3);
		chk("mode change", 0, osc);
		test_done();
	end
endmodule : bst_gate_ctrl_test
